// [src/cpld_macrocell.sv]
// one macrocell with its control terms, output buffer and APB registers
//
// Contract
// - register is D, T or bypassed combinational
// - clock chosen from four sources
// - dual global clock: pin or macrocell equation
// - rising or falling edge per global clock
// - clock terms configurable as product or sum
// - two terms asynchronously preset and reset register
// - power-up clears the register
// - preset/reset connection can be disabled
// - clock terms also selectable as output enable
// - four terms in total drive output enable
// - buffer may be always on or off
// - global three-state low floats all outputs
// - feedback of macrocell value and pin level
// - output use: buffer on, feedback kept
// - input use: buffer off, pin routed in
`include "cpld_macrocell_cfg.svh"

module cpld_macrocell
   import cpld_macrocell_pkg::*;
#(
   parameter int N_IN = 36,
   parameter int AW   = 8
) (
   input  wire logic            mclk,
   input  wire logic            arst_n,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [AW-1:0]   paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire logic [N_IN-1:0] interconnect_array,
   input  wire logic            sop_result,
   input  wire logic            global_sync_clock,
   input  wire logic            global_dual_clock,
   input  wire logic            dual_clock_equation,
   input  wire logic            global_three_state_n,
   input  wire logic            pin_in,
   output logic                 pin_out,
   output logic                 pin_oe_n,
   output logic                 fb_macrocell,
   output logic                 fb_pin,
   output logic                 ctrl_term_async_a,
   output logic                 ctrl_term_async_b,
   output logic                 ctrl_term_clk_oe_a,
   output logic                 ctrl_term_clk_oe_b,
   output logic                 ctrl_term_oe_c,
   output logic                 ctrl_term_oe_d
);

   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   // returns {valid, high word, term index}
   function automatic logic [4:0] term_slot(input logic [AW-1:0] a);
      logic [AW-1:0] off;
      off = a - AW'(`MC_TERM_BASE_OFS);
      if (a >= AW'(`MC_TERM_BASE_OFS) &&
          off < AW'(`MC_TERM_SPAN) && a[1:0] == 2'h0) begin
         return {1'b1, off[2], off[5:3]};
      end
      return 5'h00;
   endfunction

   logic [4:0] slot;
   logic       hit_cfg;
   logic       hit_status;
   logic       mapped;
   logic       wr_en;

   always_comb begin
      slot       = term_slot(paddr);
      hit_cfg    = (paddr == AW'(`MC_CFG_OFS));
      hit_status = (paddr == AW'(`MC_STATUS_OFS));
      mapped     = hit_cfg | hit_status | slot[4];
      wr_en      = psel & penable & pwrite & mapped;
   end

   // ----------------------------------------------------------------------
   // configuration and control term registers
   // ----------------------------------------------------------------------
   logic [`MC_CFG_USED_W-1:0] cfg_q;
   logic [`MC_CFG_USED_W-1:0] cfg_d;
   logic [N_IN-1:0]           mask_q [N_TERMS];
   logic [N_IN-1:0]           mask_d [N_TERMS];
   logic [N_TERMS-1:0]        or_q;
   logic [N_TERMS-1:0]        or_d;

   always_comb begin
      cfg_d  = cfg_q;
      mask_d = mask_q;
      or_d   = or_q;
      if (wr_en && hit_cfg) begin
         cfg_d = pwdata[`MC_CFG_USED_W-1:0];
      end
      if (wr_en && slot[4]) begin
         if (slot[3]) begin
            mask_d[slot[2:0]][N_IN-1:32] = pwdata[N_IN-33:0];
            or_d[slot[2:0]] = pwdata[`MC_TERM_OR_BIT];
         end else begin
            mask_d[slot[2:0]][31:0] = pwdata;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q <= `MC_CFG_RST;
         or_q  <= {N_TERMS{`MC_TERM_OR_RST}};
         for (int i = 0; i < N_TERMS; i++) begin
            mask_q[i] <= '0;
         end
      end else begin
         cfg_q  <= cfg_d;
         mask_q <= mask_d;
         or_q   <= or_d;
      end
   end

   mc_mode_t mode;
   clk_src_t clk_sel;
   oe_src_t  oe_sel;
   logic     clk_fall;
   logic     dual_from_eqn;
   logic     async_en;
   logic     gts_en;

   always_comb begin
      mode          = mc_mode_t'(cfg_q[`MC_CFG_MODE_LSB +: 2]);
      clk_sel       = clk_src_t'(cfg_q[`MC_CFG_CLKSEL_LSB +: 2]);
      oe_sel        = oe_src_t'(cfg_q[`MC_CFG_OESEL_LSB +: 3]);
      clk_fall      = cfg_q[`MC_CFG_CLKFALL];
      dual_from_eqn = cfg_q[`MC_CFG_DUALSRC];
      async_en      = cfg_q[`MC_CFG_ASYNCEN];
      gts_en        = cfg_q[`MC_CFG_GTSEN];
   end

   // ----------------------------------------------------------------------
   // control terms
   // ----------------------------------------------------------------------
   logic [N_TERMS-1:0] term;

   for (genvar g = 0; g < N_TERMS; g++) begin : g_term
      ctrl_term_eval #(
         .N_IN     (N_IN)
      ) u_term (
         .block_in (interconnect_array),
         .mask     (mask_q[g]),
         .or_type  (or_q[g]),
         .term     (term[g])
      );
   end

   always_comb begin
      ctrl_term_async_a  = term[0];
      ctrl_term_async_b  = term[1];
      ctrl_term_clk_oe_a = term[2];
      ctrl_term_clk_oe_b = term[3];
      ctrl_term_oe_c     = term[4];
      ctrl_term_oe_d     = term[5];
   end

   // ----------------------------------------------------------------------
   // clock selection and edge detection
   // ----------------------------------------------------------------------
   logic clk_now;
   logic clk_prev_q;
   logic clk_prev_d;
   logic clk_edge;
   logic dual_src;

   always_comb begin
      dual_src = dual_from_eqn ? dual_clock_equation : global_dual_clock;
      unique case (clk_sel)
         CLK_GSYNC: clk_now = global_sync_clock ^ clk_fall;
         CLK_GDUAL: clk_now = dual_src ^ clk_fall;
         CLK_CT_A:  clk_now = ctrl_term_clk_oe_a;
         CLK_CT_B:  clk_now = ctrl_term_clk_oe_b;
      endcase
      clk_prev_d = clk_now;
      clk_edge   = clk_now & ~clk_prev_q;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         clk_prev_q <= 1'b0;
      end else begin
         clk_prev_q <= clk_prev_d;
      end
   end

   // ----------------------------------------------------------------------
   // macrocell register
   // ----------------------------------------------------------------------
   logic ff_q;
   logic ff_d;
   logic force_rst;
   logic force_set;
   logic mc_value;

   always_comb begin
      // reset term wins over preset when both are active
      force_rst = async_en & ctrl_term_async_b;
      force_set = async_en & ctrl_term_async_a & ~force_rst;
      ff_d = ff_q;
      if (force_rst) begin
         ff_d = 1'b0;
      end else if (force_set) begin
         ff_d = 1'b1;
      end else if (clk_edge) begin
         unique case (mode)
            MODE_D:    ff_d = sop_result;
            MODE_T:    ff_d = ff_q ^ sop_result;
            MODE_COMB: ff_d = ff_q;
            default:   ff_d = ff_q;
         endcase
      end
      if (mode == MODE_COMB) begin
         mc_value = sop_result;
      end else if (force_rst) begin
         mc_value = 1'b0;
      end else if (force_set) begin
         mc_value = 1'b1;
      end else begin
         mc_value = ff_q;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ff_q <= 1'b0;
      end else begin
         ff_q <= ff_d;
      end
   end

   // ----------------------------------------------------------------------
   // output buffer and feedback
   // ----------------------------------------------------------------------
   logic oe_active;

   always_comb begin
      unique case (oe_sel)
         OE_OFF:  oe_active = 1'b0;
         OE_ON:   oe_active = 1'b1;
         OE_CT_A: oe_active = ctrl_term_clk_oe_a;
         OE_CT_B: oe_active = ctrl_term_clk_oe_b;
         OE_CT_C: oe_active = ctrl_term_oe_c;
         OE_CT_D: oe_active = ctrl_term_oe_d;
         default: oe_active = 1'b0;
      endcase
      if (gts_en && !global_three_state_n) begin
         oe_active = 1'b0;
      end
      pin_out      = mc_value;
      pin_oe_n     = ~oe_active;
      fb_macrocell = mc_value;
      fb_pin       = pin_in;
   end

   // ----------------------------------------------------------------------
   // apb read path
   // ----------------------------------------------------------------------
   logic [31:0] rd_mux;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_cfg) begin
         rd_mux = 32'(cfg_q);
      end else if (hit_status) begin
         rd_mux[`MC_ST_REG]   = ff_q;
         rd_mux[`MC_ST_VALUE] = mc_value;
         rd_mux[`MC_ST_PIN]   = pin_in;
         rd_mux[`MC_ST_OE]    = oe_active;
         rd_mux[`MC_ST_TERM_LSB +: N_TERMS] = term;
         rd_mux[`MC_ST_GTS]   = global_three_state_n;
      end else if (slot[4] && slot[3]) begin
         rd_mux[N_IN-33:0] = mask_q[slot[2:0]][N_IN-1:32];
         rd_mux[`MC_TERM_OR_BIT] = or_q[slot[2:0]];
      end else if (slot[4]) begin
         rd_mux = mask_q[slot[2:0]][31:0];
      end
      prdata_d = prdata_q;
      if (psel && !penable) begin
         prdata_d = rd_mux;
      end
      prdata  = prdata_q;
      pready  = 1'b1;
      pslverr = psel & penable & ~mapped;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

endmodule // cpld_macrocell

// [src/cpld_macrocell_cfg.svh]
// register offsets, field positions and reset values of the macrocell
`ifndef CPLD_MACROCELL_CFG_SVH
`define CPLD_MACROCELL_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define MC_CFG_OFS        8'h00
`define MC_STATUS_OFS     8'h04
`define MC_TERM_BASE_OFS  8'h10
`define MC_TERM_STEP      8'h08
`define MC_TERM_SPAN      8'h30

// ----------------------------------------------------------------------
// configuration field positions
// ----------------------------------------------------------------------
`define MC_CFG_MODE_LSB   0
`define MC_CFG_CLKSEL_LSB 2
`define MC_CFG_CLKFALL    4
`define MC_CFG_DUALSRC    5
`define MC_CFG_ASYNCEN    6
`define MC_CFG_OESEL_LSB  7
`define MC_CFG_GTSEN      10
`define MC_CFG_USED_W     11

// ----------------------------------------------------------------------
// term register and status fields
// ----------------------------------------------------------------------
`define MC_TERM_OR_BIT    8
`define MC_ST_REG         0
`define MC_ST_VALUE       1
`define MC_ST_PIN         2
`define MC_ST_OE          3
`define MC_ST_TERM_LSB    4
`define MC_ST_GTS         10

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MC_CFG_RST        11'h000
`define MC_TERM_OR_RST    1'b0

`endif

// [src/cpld_macrocell_pkg.sv]
// types shared by the macrocell design
package cpld_macrocell_pkg;

   // ----------------------------------------------------------------------
   // register mode, clock source and output enable source
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_COMB = 2'h0,
      MODE_D    = 2'h1,
      MODE_T    = 2'h2,
      MODE_RSVD = 2'h3
   } mc_mode_t;

   typedef enum logic [1:0] {
      CLK_GSYNC = 2'h0,
      CLK_GDUAL = 2'h1,
      CLK_CT_A  = 2'h2,
      CLK_CT_B  = 2'h3
   } clk_src_t;

   typedef enum logic [2:0] {
      OE_OFF  = 3'h0,
      OE_ON   = 3'h1,
      OE_CT_A = 3'h2,
      OE_CT_B = 3'h3,
      OE_CT_C = 3'h4,
      OE_CT_D = 3'h5
   } oe_src_t;

   localparam int N_TERMS = 6;

endpackage

// [src/ctrl_term_eval.sv]
// one control term: product or sum of the masked block inputs
module ctrl_term_eval #(
   parameter int N_IN = 36
) (
   input  wire logic [N_IN-1:0] block_in,
   input  wire logic [N_IN-1:0] mask,
   input  wire logic            or_type,
   output logic                 term
);

   // an empty product is one, an empty sum is zero
   always_comb begin
      if (or_type) begin
         term = |(block_in & mask);
      end else begin
         term = &(block_in | ~mask);
      end
   end

endmodule // ctrl_term_eval

// [tb/cpld_macrocell_monitor.sv]
// checker of the macrocell port behaviour, bound to the design
module cpld_macrocell_monitor
   import cpld_macrocell_pkg::*;
#(
   parameter int N_IN = 36,
   parameter int AW   = 8
) (
   input wire logic          mclk,
   input wire logic          arst_n,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0]   pwdata,
   input wire logic          sop_result,
   input wire logic          global_sync_clock,
   input wire logic          global_three_state_n,
   input wire logic          pin_in,
   input wire logic          pin_out,
   input wire logic          pin_oe_n,
   input wire logic          fb_macrocell,
   input wire logic          fb_pin,
   input wire logic          ctrl_term_async_a,
   input wire logic          ctrl_term_async_b,
   input wire logic          ctrl_term_clk_oe_a,
   input wire logic          ctrl_term_clk_oe_b,
   input wire logic          ctrl_term_oe_c,
   input wire logic          ctrl_term_oe_d
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [10:0] cfg_q;
   logic [10:0] cfg_d;
   logic        oe_term;
   logic        frc;
   // ----
   // shadow of the configuration word
   // ----
   always_comb begin
      cfg_d = cfg_q;
      if (psel && penable && pwrite && paddr == '0) cfg_d = pwdata[10:0];
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) cfg_q <= 11'h000;
      else cfg_q <= cfg_d;
   end
   always_comb begin
      case (cfg_q[9:7])
         3'h2: oe_term = ctrl_term_clk_oe_a;
         3'h3: oe_term = ctrl_term_clk_oe_b;
         3'h4: oe_term = ctrl_term_oe_c;
         default: oe_term = ctrl_term_oe_d;
      endcase
   end
   assign frc = cfg_q[6] && (cfg_q[1:0] == 2'h1 || cfg_q[1:0] == 2'h2);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   comb_path_a: assert property (
      cfg_q[1:0] == 2'h0 |-> fb_macrocell == sop_result)
      else $error("comb path wrong");
   d_capture_a: assert property (
      cfg_q[6:0] == 7'h01 && $rose(global_sync_clock)
      |=> fb_macrocell == $past(sop_result)) else $error("d capture");
   t_toggle_a: assert property (
      cfg_q[6:0] == 7'h02 && $rose(global_sync_clock) && sop_result
      |=> fb_macrocell != $past(fb_macrocell)) else $error("no toggle");
   oe_term_a: assert property (
      cfg_q[9:7] inside {[2:5]} && !cfg_q[10] |-> pin_oe_n == !oe_term)
      else $error("oe term");
   oe_fixed_a: assert property (
      cfg_q[9:7] != 3'h1 && !(cfg_q[9:7] inside {[2:5]}) |-> pin_oe_n)
      else $error("oe fixed");
   gts_float_a: assert property (
      cfg_q[10] && !global_three_state_n |-> pin_oe_n)
      else $error("gts float");
   pin_fb_a: assert property (
      fb_pin == pin_in && pin_out == fb_macrocell &&
      (pin_oe_n || fb_pin == fb_macrocell)) else $error("feedback");
   reset_force_a: assert property (
      frc && ctrl_term_async_b |-> !fb_macrocell) else $error("reset");
   preset_force_a: assert property (
      frc && ctrl_term_async_a && !ctrl_term_async_b |-> fb_macrocell)
      else $error("preset");
   rst_state_a: assert property (disable iff (1'b0)
      !arst_n |-> pin_oe_n && fb_macrocell == sop_result)
      else $error("reset state");
   cover property (frc && ctrl_term_async_a);
   cover property (cfg_q[1:0] == 2'h2 && $rose(global_sync_clock));
   cover property (cfg_q[10] && !global_three_state_n);
endmodule // cpld_macrocell_monitor

bind cpld_macrocell cpld_macrocell_monitor #(.N_IN(N_IN), .AW(AW))
   cpld_macrocell_monitor_inst (.mclk, .arst_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .sop_result, .global_sync_clock, .global_three_state_n,
   .pin_in, .pin_out, .pin_oe_n, .fb_macrocell, .fb_pin, .ctrl_term_async_a,
   .ctrl_term_async_b, .ctrl_term_clk_oe_a, .ctrl_term_clk_oe_b,
   .ctrl_term_oe_c, .ctrl_term_oe_d);

// [tb/cpld_pin_model.sv]
// behavioural model of the device pin and its outside driver
module cpld_pin_model (
   input  wire logic pin_out,
   input  wire logic pin_oe_n,
   input  wire logic ext_en,
   input  wire logic ext_val,
   output logic      pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_q = 1'b0;
   // a released pin shows the inverse of its last driven level
   always @* begin
      if (!pin_oe_n) pin_in = pin_out;
      else if (ext_en) pin_in = ext_val;
      else pin_in = ~last_q;
   end
   always @(pin_in) if (!pin_oe_n || ext_en) last_q = pin_in;
endmodule // cpld_pin_model

// [tb/cpld_macrocell_tb.sv]
// self-checking bench of the macrocell over its register bus and pins
module cpld_macrocell_tb
   import cpld_macrocell_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [35:0] interconnect_array;
   logic        sop_result, global_sync_clock, global_dual_clock;
   logic        dual_clock_equation, global_three_state_n, pin_in;
   logic        pin_out, pin_oe_n, fb_macrocell, fb_pin, ext_en, ext_val;
   logic        err, cur, ctrl_term_async_a, ctrl_term_async_b;
   logic        ctrl_term_clk_oe_a, ctrl_term_clk_oe_b;
   logic        ctrl_term_oe_c, ctrl_term_oe_d;
   int          num_errors = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          sel[6] = '{0, 0, 1, 1, 2, 3};
   int          fal[6] = '{0, 1, 0, 1, 0, 0};
   int          dua[6] = '{0, 0, 0, 1, 0, 0};
   int          src[6] = '{0, 0, 1, 2, 3, 3};

   cpld_macrocell cpld_macrocell_inst (.mclk, .arst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .interconnect_array, .sop_result, .global_sync_clock,
      .global_dual_clock, .dual_clock_equation, .global_three_state_n,
      .pin_in, .pin_out, .pin_oe_n, .fb_macrocell, .fb_pin,
      .ctrl_term_async_a, .ctrl_term_async_b, .ctrl_term_clk_oe_a,
      .ctrl_term_clk_oe_b, .ctrl_term_oe_c, .ctrl_term_oe_d);
   cpld_pin_model cpld_pin_model_inst (.pin_out, .pin_oe_n, .ext_en,
      .ext_val, .pin_in);

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         report_and_stop();
      end
   end
   // ----
   // bus, pin and compare tasks
   // ----
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic check_word(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic check_bit(input string n, input logic e, g);
      check_word(n, {31'h0, e}, {31'h0, g});
   endtask
   task automatic drv(input int s, input logic v);
      case (s)
         0: global_sync_clock <= v;
         1: global_dual_clock <= v;
         2: dual_clock_equation <= v;
         default: interconnect_array[35] <= v;
      endcase
   endtask
   task automatic term_chk(input logic [35:0] v, input logic e);
      interconnect_array <= v;
      tick(1);
      check_bit("term", e, ctrl_term_clk_oe_a);
   endtask
   task automatic oe_case(input logic [31:0] c, input logic g, e);
      apb(1'b1, 8'h00, c);
      global_three_state_n <= g;
      tick(1);
      check_bit("oe_n", e, pin_oe_n);
   endtask
   task automatic pulse;
      drv(0, 1'b1);
      tick(3);
      drv(0, 1'b0);
      tick(3);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----
   // test sequence
   // ----
   initial begin
      arst_n = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {interconnect_array, sop_result, global_sync_clock} = '0;
      {global_dual_clock, dual_clock_equation, ext_val} = '0;
      {global_three_state_n, ext_en} = 2'h3;
      // reset falls after time zero so every register sees its edge
      #1 arst_n = 1'b0;
      tick(8);
      check_bit("oe_n", 1'b1, pin_oe_n);
      arst_n <= 1'b1;
      apb(1'b0, 8'h04, 32'h0);
      check_word("status", 32'h0000_07f0, rd);
      apb(1'b0, 8'h08, 32'h0);
      check_bit("slverr", 1'b1, err);
      $display("reset test done");
      apb(1'b1, 8'h20, 32'h1);
      apb(1'b1, 8'h24, 32'h8);
      term_chk(36'h0_0000_0001, 1'b0);
      term_chk(36'h8_0000_0001, 1'b1);
      apb(1'b1, 8'h24, 32'h108);
      term_chk(36'h8_0000_0000, 1'b1);
      term_chk(36'h0_0000_0000, 1'b0);
      $display("term test done");
      apb(1'b1, 8'h34, 32'h100);
      sop_result <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         ext_en <= ~k[0];
         oe_case(32'(k) << 7, 1'b1, ~k[0]);
         check_bit("fb_pin", k[0], fb_pin);
         check_bit("fb_mc", 1'b1, fb_macrocell);
      end
      ext_en <= 1'b0;
      oe_case(32'h480, 1'b0, 1'b1);
      oe_case(32'h480, 1'b1, 1'b0);
      oe_case(32'h080, 1'b0, 1'b0);
      ext_en <= 1'b1;
      oe_case(32'h000, 1'b1, 1'b1);
      oe_case(32'h300, 1'b1, 1'b1);
      $display("output enable test done");
      apb(1'b1, 8'h2c, 32'h108);
      cur = 1'b0;
      for (int j = 0; j < 6; j++) begin
         sop_result <= cur;
         apb(1'b1, 8'h00, 32'(1 + sel[j] * 4 + fal[j] * 16 + dua[j] * 32));
         tick(2);
         sop_result <= ~cur;
         drv(src[j], 1'b1);
         tick(3);
         check_bit("rise", fal[j] ? cur : ~cur, fb_macrocell);
         drv(src[j], 1'b0);
         tick(3);
         check_bit("fall", ~cur, fb_macrocell);
         cur = ~cur;
      end
      sop_result <= 1'b0;
      apb(1'b1, 8'h00, 32'(MODE_T));
      for (int j = 0; j < 3; j++) begin
         sop_result <= (j != 0);
         pulse();
         if (j != 0) cur = ~cur;
         check_bit("toggle", cur, fb_macrocell);
      end
      apb(1'b1, 8'h00, 32'h3);
      sop_result <= 1'b1;
      pulse();
      check_bit("reserved", cur, fb_macrocell);
      $display("clocking test done");
      apb(1'b1, 8'h10, 32'h4);
      apb(1'b1, 8'h14, 32'h100);
      apb(1'b1, 8'h18, 32'h8);
      apb(1'b1, 8'h1c, 32'h100);
      apb(1'b1, 8'h00, 32'(MODE_D));
      interconnect_array <= 36'h4;
      tick(2);
      check_bit("no_preset", 1'b0, fb_macrocell);
      apb(1'b1, 8'h00, 32'h41);
      tick(1);
      check_bit("preset", 1'b1, fb_macrocell);
      apb(1'b0, 8'h00, 32'h0);
      check_word("cfg", 32'h0000_0041, rd);
      apb(1'b0, 8'h18, 32'h0);
      check_word("term_lo", 32'h0000_0008, rd);
      apb(1'b0, 8'h1c, 32'h0);
      check_word("term_hi", 32'h0000_0100, rd);
      interconnect_array <= 36'hc;
      sop_result <= 1'b1;
      pulse();
      check_bit("reset", 1'b0, fb_macrocell);
      interconnect_array <= 36'h4;
      tick(2);
      interconnect_array <= 36'h0;
      tick(2);
      check_bit("held", 1'b1, fb_macrocell);
      $display("async test done");
      arst_n <= 1'b0;
      tick(2);
      arst_n <= 1'b1;
      apb(1'b0, 8'h04, 32'h0);
      check_bit("cleared", 1'b0, rd[0]);
      $display("second reset test done");
      report_and_stop();
   end
endmodule // cpld_macrocell_tb
